//--- rtl/mhb_master_engine.sv
// Master parallel bus engine: internal accesses to external strobes.
// Assumes synchronous pins and a master keeping accStart off while busy.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module mhb_master_engine
   import mhb_pkg::*;
#(
   parameter int NWIN = 4
)
(
   input  wire logic            ref_clk,
   input  wire logic            rstn,
   input  wire mhb_reg_req_t    regReq,
   output var  logic [31:0]     regRdData,
   input  wire mhb_acc_req_t    accReq,
   output var  logic            accBusy,
   output var  logic            accDone,
   output var  logic            accTimedOut,
   output var  logic [15:0]     accRdData,
   input  wire logic [15:0]     busDataIn,
   input  wire logic            waitPinIn,
   input  wire logic            dmaReqIn,
   output var  mhb_pins_t       busPins,
   output var  logic [NWIN-1:0] windowSelectOut,
   output var  logic            irqOut
);

   localparam int WIX = (NWIN > 1) ? $clog2(NWIN) : 1;

   typedef struct packed {
      mhb_state_t                st;
      mhb_win_cfg_t [NWIN-1:0]   cfg;
      mhb_win_tim_t [NWIN-1:0]   tim;
      logic [1:0]                pend;
      logic [1:0]                irqEn;
      logic                      tick;
      logic                      held;
      mhb_acc_req_t              acc;
      logic [WIX-1:0]            win;
      logic [7:0]                cnt;
      logic [7:0]                toCnt;
      logic [31:0]               rdData;
      logic                      done;
      logic                      timedOut;
      logic [15:0]               accData;
      logic                      selAct;
      logic                      latchAct;
      mhb_pins_t                 pins;
      logic [NWIN-1:0]           sel;
      logic                      irq;
   } mhb_core_t;

   mhb_core_t    s;
   mhb_core_t    next_s;
   mhb_win_cfg_t c;
   mhb_win_tim_t t;
   logic         waitAct;
   logic         dmaSync;
   logic         toHit;
   logic         dWaitOn;
   logic         aWaitOn;
   logic         anyHit;
   logic [WIX-1:0] hitIx;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [2:0] regKind(input logic [7:0] a);
      logic [2:0] k;
      k = RK_NONE;
      if (a[1:0] != 2'h0)
         k = RK_NONE;
      else if (a == PEND_OFS)
         k = RK_PEND;
      else if (a == EN_SET_OFS)
         k = RK_ENSET;
      else if (a == EN_CLR_OFS)
         k = RK_ENCLR;
      else if ({3'h0, a[7:3]} < 8'(NWIN))
         k = a[2] ? RK_TIM : RK_CFG;
      return k;
   endfunction : regKind

   // Zero counts still last one bus clock so every phase is visible
   function automatic logic [7:0] ld(input logic [3:0] v, input logic [1:0] ps);
      logic [7:0] x;
      x = {4'h0, v} << ps;
      return (x == 8'h00) ? 8'h00 : x - 8'h01;
   endfunction : ld

   // Byte swap is its own inverse, so reads and writes share it
   function automatic logic [15:0] fmt(input logic [15:0] d, input mhb_win_cfg_t w);
      logic [15:0] r;
      r = w.byteOrder ? {d[7:0], d[15:8]} : d;
      if (!w.widthSelect)
         r = {8'h00, d[7:0]};
      return r;
   endfunction : fmt

   function automatic logic hit(input mhb_win_cfg_t w, input logic [11:0] a);
      return w.valid && (((a ^ w.base) & w.compareMask) == 12'h000);
   endfunction : hit

   // ----------------------------------------
   // Pin samplers
   // ----------------------------------------
   mhb_pin_sync u_dma_sync (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .tick      (s.tick),
      .pinIn     (dmaReqIn),
      .activeLow (t.dmaPolarity),
      .level     (dmaSync)
   );

   mhb_pin_sync u_wait_sync (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .tick      (s.tick),
      .pinIn     (waitPinIn),
      .activeLow (t.waitPolarity),
      .level     (waitAct)
   );

   assign c       = s.cfg[s.win];
   assign t       = s.tim[s.win];
   assign toHit   = t.timeoutEnable && (s.toCnt >= t.timeoutClocks);
   assign dWaitOn = c.waitEnable[0] || t.timeoutEnable;
   assign aWaitOn = c.waitEnable[1] || t.timeoutEnable;

   // Lowest numbered matching window wins
   always_comb
   begin
      anyHit = 1'b0;
      hitIx  = '0;
      for (int i = NWIN - 1; i >= 0; i--)
      begin
         if (hit(s.cfg[i], s.acc.addr[23:12]))
         begin
            anyHit = 1'b1;
            hitIx  = WIX'(i);
         end
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      logic goData;
      logic finish;
      logic tmo;
      logic [2:0] k;
      goData = 1'b0;
      finish = 1'b0;
      tmo    = 1'b0;
      k      = regKind(regReq.addr);
      next_s = s;
      next_s.tick = ~s.tick;
      next_s.done = 1'b0;
      next_s.rdData = 32'h0000_0000;

      if (regReq.rd)
      begin
         case (k)
            RK_CFG:   next_s.rdData = s.cfg[regReq.addr[3+:WIX]];
            RK_TIM:   next_s.rdData = s.tim[regReq.addr[3+:WIX]];
            RK_PEND:  next_s.rdData = {30'h0, s.pend};
            RK_ENSET,
            RK_ENCLR: next_s.rdData = {30'h0, s.irqEn};
            default:  next_s.rdData = 32'h0000_0000;
         endcase
      end
      if (regReq.wr)
      begin
         case (k)
            RK_CFG:   next_s.cfg[regReq.addr[3+:WIX]] = regReq.data;
            RK_TIM:   next_s.tim[regReq.addr[3+:WIX]] = regReq.data;
            RK_PEND:  next_s.pend = s.pend & ~regReq.data[1:0];
            RK_ENSET: next_s.irqEn = s.irqEn | regReq.data[1:0];
            RK_ENCLR: next_s.irqEn = s.irqEn & ~regReq.data[1:0];
            default:  next_s.irqEn = s.irqEn;
         endcase
      end

      if (accReq.start && !s.held)
      begin
         next_s.held = 1'b1;
         next_s.acc  = accReq;
      end

      if (s.tick)
      begin
         case (s.st)
            ST_IDLE:
               if (s.held)
               begin
                  if (!anyHit)
                  begin
                     next_s.pend[PEND_UM] = 1'b1;
                     next_s.done     = 1'b1;
                     next_s.held     = 1'b0;
                     next_s.timedOut = 1'b0;
                     next_s.accData  = 16'h0000;
                  end
                  else
                  begin
                     next_s.win = hitIx;
                     next_s.st  = ST_ARM;
                  end
               end
            ST_ARM:
               if (!c.dmaWaitEnable || dmaSync)
               begin
                  next_s.selAct    = 1'b1;
                  next_s.pins.addr = s.acc.addr[22:0];
                  next_s.toCnt     = 8'h00;
                  if (c.sharedBus)
                  begin
                     next_s.st          = ST_SETUP;
                     next_s.cnt         = ld({2'h0, t.latchSetupClocks}, t.prescaler);
                     next_s.pins.data   = s.acc.addr[15:0];
                     next_s.pins.dataOe = 1'b1;
                  end
                  else
                     goData = 1'b1;
               end
            ST_SETUP:
               if (s.cnt != 8'h00)
                  next_s.cnt = s.cnt - 8'h01;
               else
               begin
                  next_s.st       = ST_LATCH;
                  next_s.latchAct = 1'b1;
                  next_s.cnt = ld({2'h0, t.latchWidthClocks} + 4'h1, t.prescaler);
               end
            ST_LATCH:
               if (s.cnt != 8'h00)
                  next_s.cnt = s.cnt - 8'h01;
               else
               begin
                  next_s.st       = ST_LHOLD;
                  next_s.latchAct = 1'b0;
                  next_s.cnt = ld({2'h0, t.latchHoldClocks}, t.prescaler);
               end
            ST_LHOLD:
               if (s.cnt != 8'h00)
                  next_s.cnt = s.cnt - 8'h01;
               else if (aWaitOn && waitAct && toHit)
               begin
                  tmo    = 1'b1;
                  finish = 1'b1;
               end
               else if (aWaitOn && waitAct)
                  next_s.toCnt = s.toCnt + 8'h01;
               else
                  goData = 1'b1;
            ST_DATA:
            begin
               next_s.pins.wrN = !s.acc.write;
               if (s.cnt != 8'h00)
                  next_s.cnt = s.cnt - 8'h01;
               else if (dWaitOn && waitAct && toHit)
               begin
                  tmo    = 1'b1;
                  finish = 1'b1;
               end
               else if (dWaitOn && waitAct)
                  next_s.toCnt = s.toCnt + 8'h01;
               else if (s.acc.write)
               begin
                  next_s.pins.wrN = 1'b1;
                  next_s.st  = ST_HOLD;
                  next_s.cnt = ld({2'h0, t.wrHoldClocks}, t.prescaler);
               end
               else
               begin
                  next_s.accData = fmt(busDataIn, c);
                  if (t.readHold)
                  begin
                     next_s.st  = ST_HOLD;
                     next_s.cnt = 8'h00;
                  end
                  else
                     finish = 1'b1;
               end
            end
            ST_HOLD:
               if (s.cnt != 8'h00)
                  next_s.cnt = s.cnt - 8'h01;
               else
                  finish = 1'b1;
            ST_GAP:
               if (s.cnt != 8'h00)
                  next_s.cnt = s.cnt - 8'h01;
               else
                  next_s.st = ST_IDLE;
            default:
               next_s.st = ST_IDLE;
         endcase
      end

      if (goData)
      begin
         next_s.st          = ST_DATA;
         next_s.cnt = ld(t.readSampleDelay, t.prescaler) + {7'h00, s.acc.write && t.wrDelay};
         next_s.toCnt       = 8'h00;
         next_s.pins.rdN    = s.acc.write;
         next_s.pins.wrN    = !(s.acc.write && !t.wrDelay);
         next_s.pins.dataOe = s.acc.write;
         next_s.pins.data   = fmt(s.acc.data, c);
      end
      if (finish)
      begin
         next_s.selAct      = 1'b0;
         next_s.latchAct    = 1'b0;
         next_s.pins.rdN    = 1'b1;
         next_s.pins.wrN    = 1'b1;
         next_s.pins.dataOe = 1'b0;
         next_s.done        = 1'b1;
         next_s.held        = 1'b0;
         next_s.timedOut    = tmo;
         if (tmo)
            next_s.pend[PEND_TO] = 1'b1;
         if (t.idleClocks == 3'h0)
            next_s.st = ST_IDLE;
         else
         begin
            next_s.st  = ST_GAP;
            next_s.cnt = ld({1'h0, t.idleClocks}, t.prescaler);
         end
      end

      next_s.irq = |(next_s.pend & next_s.irqEn);
      next_s.pins.latch = next_s.latchAct ^ next_s.tim[next_s.win].latchEdge;
      for (int i = 0; i < NWIN; i++)
         next_s.sel[i] = (next_s.selAct && next_s.win == WIX'(i)) ^ next_s.tim[i].selectPolarity;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         s          <= '0;
         s.st       <= ST_IDLE;
         s.pins.rdN <= 1'b1;
         s.pins.wrN <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign regRdData       = s.rdData;
   assign accBusy         = s.held;
   assign accDone         = s.done;
   assign accTimedOut     = s.timedOut;
   assign accRdData       = s.accData;
   assign busPins         = s.pins;
   assign windowSelectOut = s.sel;
   assign irqOut          = s.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence seqReadSample;
      s.tick && s.st == ST_DATA && s.cnt == 8'h00 && !s.acc.write && !(dWaitOn && waitAct);
   endsequence

   AST_BUS_DIV: assert property (s.tick |=> !s.tick ##1 s.tick)
      else $error("bus enable is not every second clock");
   AST_NO_WAIT: assert property (s.tick && s.st == ST_DATA && s.cnt == 8'h00
      && !dWaitOn |=> s.st != ST_DATA) else $error("waited with waiting off");
   AST_TO_FORCE: assert property (s.tick && s.st == ST_DATA && s.cnt == 8'h00
      && t.timeoutEnable && waitAct && !toHit |=> s.st == ST_DATA)
      else $error("timeout enable did not force waiting");
   AST_WIDTH8: assert property (seqReadSample ##0 !c.widthSelect
      |=> s.accData[15:8] == 8'h00) else $error("8-bit read kept upper byte");
   AST_SEL_HIT: assert property (s.selAct |-> hit(c, s.acc.addr[23:12]))
      else $error("select active without window match");
   AST_WR_NODELAY: assert property ($rose(s.st == ST_DATA) && s.acc.write
      && !t.wrDelay |-> !s.pins.wrN) else $error("write strobe late");
   AST_WR_DELAY: assert property ($rose(s.st == ST_DATA) && s.acc.write
      && t.wrDelay |-> s.pins.wrN ##2 !s.pins.wrN) else $error("write strobe not delayed");
   AST_RD_REL: assert property (seqReadSample ##0 !t.readHold |=> s.pins.rdN)
      else $error("read strobe held without hold bit");
   AST_RD_HOLD: assert property (seqReadSample ##0 t.readHold
      |=> !s.pins.rdN ##2 s.pins.rdN) else $error("read hold not one clock");
   AST_TIMEOUT: assert property (s.tick && s.st == ST_DATA && s.cnt == 8'h00
      && dWaitOn && waitAct && toHit |=> s.st != ST_DATA && s.pend[PEND_TO] && s.done)
      else $error("timeout did not end access");
   AST_UNMAP: assert property (s.tick && s.st == ST_IDLE && s.held && !anyHit
      |=> s.pend[PEND_UM] && s.done) else $error("unmapped access not flagged");
   AST_GAP: assert property ($rose(s.st == ST_GAP) |-> !s.selAct
      && s.cnt == ld({1'h0, t.idleClocks}, t.prescaler)) else $error("idle gap wrong");
   AST_SETUP: assert property ($rose(s.latchAct) |-> $past(s.st) == ST_SETUP)
      else $error("latch strobe without setup phase");
   AST_EN_SET: assert property (regReq.wr && regReq.addr == EN_SET_OFS
      && regReq.data[0] |=> s.irqEn[0]) else $error("enable set port ignored");

endmodule : mhb_master_engine
`default_nettype wire

//--- rtl/mhb_pkg.sv
// Shared types and constants of the master parallel bus engine.
// Assumes a single 100 MHz clock with the bus rate made by an enable.
package mhb_pkg;

   // ----------------------------------------
   // Register map (byte offsets)
   // ----------------------------------------
   localparam logic [7:0] WIN_STRIDE = 8'h08;
   localparam logic [7:0] PEND_OFS   = 8'h40;
   localparam logic [7:0] EN_SET_OFS = 8'h44;
   localparam logic [7:0] EN_CLR_OFS = 8'h48;

   localparam logic [2:0] RK_NONE  = 3'h0;
   localparam logic [2:0] RK_CFG   = 3'h1;
   localparam logic [2:0] RK_TIM   = 3'h2;
   localparam logic [2:0] RK_PEND  = 3'h3;
   localparam logic [2:0] RK_ENSET = 3'h4;
   localparam logic [2:0] RK_ENCLR = 3'h5;

   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [31:0] CFG_RST  = 32'h0000_0000;
   localparam logic [31:0] TIM_RST  = 32'h0000_0000;
   localparam logic [1:0]  PEND_RST = 2'h0;
   localparam logic [1:0]  IRQ_RST  = 2'h0;
   localparam int          BUS_DIV  = 2;
   localparam int          PEND_TO  = 1;
   localparam int          PEND_UM  = 0;

   // ----------------------------------------
   // Field layouts
   // ----------------------------------------
   typedef struct packed {
      logic        addrIncInhibit;
      logic [1:0]  waitEnable;
      logic        dmaWaitEnable;
      logic        sharedBus;
      logic        byteOrder;
      logic        widthSelect;
      logic        valid;
      logic [11:0] compareMask;
      logic [11:0] base;
   } mhb_win_cfg_t;

   typedef struct packed {
      logic       readHold;
      logic       dmaPolarity;
      logic       waitPolarity;
      logic       selectPolarity;
      logic       latchEdge;
      logic       wrDelay;
      logic       timeoutEnable;
      logic [1:0] prescaler;
      logic [2:0] idleClocks;
      logic [7:0] timeoutClocks;
      logic [1:0] wrHoldClocks;
      logic [3:0] readSampleDelay;
      logic [1:0] latchHoldClocks;
      logic [1:0] latchWidthClocks;
      logic [1:0] latchSetupClocks;
   } mhb_win_tim_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] data;
   } mhb_reg_req_t;

   typedef struct packed {
      logic        start;
      logic        write;
      logic [23:0] addr;
      logic [15:0] data;
   } mhb_acc_req_t;

   typedef struct packed {
      logic [22:0] addr;
      logic        latch;
      logic        rdN;
      logic        wrN;
      logic [15:0] data;
      logic        dataOe;
   } mhb_pins_t;

   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_ARM   = 8'h02,
      ST_SETUP = 8'h04,
      ST_LATCH = 8'h08,
      ST_LHOLD = 8'h10,
      ST_DATA  = 8'h20,
      ST_HOLD  = 8'h40,
      ST_GAP   = 8'h80
   } mhb_state_t;

endpackage : mhb_pkg

//--- rtl/mhb_pin_sync.sv
// Bus-rate sampler for one external request or wait pin.
// Assumes the pin is synchronous to ref_clk and tick is the bus enable.
`timescale 1ns/1ps
`default_nettype none
module mhb_pin_sync
(
   input  wire logic ref_clk,
   input  wire logic rstn,
   input  wire logic tick,
   input  wire logic pinIn,
   input  wire logic activeLow,
   output var  logic level
);

   typedef struct packed {
      logic level;
   } mhb_sync_t;

   mhb_sync_t s;
   mhb_sync_t next_s;

   always_comb
   begin
      next_s = s;
      if (tick)
      begin
         next_s.level = pinIn ^ activeLow;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         s <= '0;
      else
         s <= next_s;
   end

   assign level = s.level;

   AST_SYNC_DELAY: assert property (@(posedge ref_clk) disable iff (!rstn)
      tick && (pinIn ^ activeLow) |=> level)
      else $error("synced request not one bus clock after pin");

   AST_SYNC_POL: assert property (@(posedge ref_clk) disable iff (!rstn)
      tick && activeLow && pinIn |=> !level)
      else $error("active-low request seen while pin high");

endmodule : mhb_pin_sync
`default_nettype wire

//--- tb/mhb_periph_model.sv
// Peripheral model on the far side of the master bus engine.
// Assumes active-high selects and pins driven from ref_clk.
`timescale 1ns/1ps
`default_nettype none
module mhb_periph_model
   import mhb_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire mhb_pins_t   busPins,
   input  wire logic [3:0]  windowSelectOut,
   input  wire logic        holdWait,
   input  wire logic        dmaOn,
   input  wire logic        dmaLow,
   output var  logic [15:0] busDataIn,
   output var  logic        waitPinIn,
   output var  logic        dmaReqIn,
   output var  logic [15:0] lastWr
);
   logic tog = 1'b0;
   logic drive;
   always_comb drive = !busPins.rdN && (|windowSelectOut);
   // Released bus toggles, so a late sample never looks valid
   always_comb busDataIn = drive ? (busPins.addr[15:0] ^ 16'h5A3C) : ({16{tog}} ^ 16'hA5A5);
   always_comb waitPinIn = holdWait;
   always_comb dmaReqIn = dmaOn ^ dmaLow;
   always @(posedge ref_clk)
   begin
      tog <= ~tog;
      if (!busPins.wrN && busPins.dataOe) lastWr <= busPins.data;
   end
endmodule : mhb_periph_model
`default_nettype wire

//--- tb/master_host_bus_interface_tb.sv
// Self-checking bench of the master bus engine with a peripheral model.
// Assumes one 100 MHz clock and window 0 as the target of accesses.
`timescale 1ns/1ps
`default_nettype none
module master_host_bus_interface_tb
   import mhb_pkg::*;
;
   logic         ref_clk = 1'b0;
   logic         rstn = 1'b0;
   mhb_reg_req_t regReq = '0;
   mhb_acc_req_t accReq = '0;
   logic [31:0]  regRdData, rd, rv;
   logic         accBusy, accDone, accTimedOut, irqOut, waitPinIn, dmaReqIn;
   logic [15:0]  accRdData, busDataIn, lastWr, d;
   mhb_pins_t    busPins;
   logic [3:0]   windowSelectOut, selSeen;
   logic         holdWait = 1'b0, dmaOn = 1'b0, dmaLow = 1'b0, selPrev = 1'b0, wrPrev = 1'b1;
   logic [11:0]  base, mask, top;
   logic [23:0]  a;
   logic         w, hit, latchSeen;
   time          selT, wrT;
   int           n_fail = 0, samples_checked = 0, accCycles;
   logic [7:0]   regTab [5] = '{8'h00, 8'h04, 8'h40, 8'h44, 8'h4C};

   always #5 ref_clk = ~ref_clk;

   mhb_master_engine #(.NWIN(4)) dut (.ref_clk(ref_clk), .rstn(rstn), .regReq(regReq),
      .regRdData(regRdData), .accReq(accReq), .accBusy(accBusy), .accDone(accDone),
      .accTimedOut(accTimedOut), .accRdData(accRdData), .busDataIn(busDataIn),
      .waitPinIn(waitPinIn), .dmaReqIn(dmaReqIn), .busPins(busPins),
      .windowSelectOut(windowSelectOut), .irqOut(irqOut));
   mhb_periph_model peer (.ref_clk(ref_clk), .busPins(busPins),
      .windowSelectOut(windowSelectOut), .holdWait(holdWait), .dmaOn(dmaOn), .dmaLow(dmaLow),
      .busDataIn(busDataIn), .waitPinIn(waitPinIn), .dmaReqIn(dmaReqIn), .lastWr(lastWr));

   always @(posedge ref_clk)
   begin
      if (windowSelectOut[0] && !selPrev) selT <= $time;
      if (!busPins.wrN && wrPrev) wrT <= $time;
      selPrev <= windowSelectOut[0];
      wrPrev <= busPins.wrN;
      selSeen <= selSeen | windowSelectOut;
      latchSeen <= latchSeen | busPins.latch;
   end

   // ----------------------------------------
   // Tasks and expectations
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic end_sim();
      if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim

   task automatic wreg(input logic [7:0] ad, input logic [31:0] v);
      @(posedge ref_clk);
      regReq <= '{1'b1, 1'b0, ad, v};
      @(posedge ref_clk);
      regReq.wr <= 1'b0;
   endtask : wreg

   task automatic rreg(input logic [7:0] ad);
      @(posedge ref_clk);
      regReq <= '{1'b0, 1'b1, ad, 32'h0};
      @(posedge ref_clk);
      regReq.rd <= 1'b0;
      #1 rd = regRdData;
   endtask : rreg

   task automatic acc(input logic wr, input logic [23:0] ad, input logic [15:0] dt);
      #1 selSeen = '0;
      latchSeen = 1'b0;
      @(posedge ref_clk);
      accReq <= '{1'b1, wr, ad, dt};
      @(posedge ref_clk);
      accReq.start <= 1'b0;
      #1 chk("accBusy", accBusy, 1'b1);
      for (accCycles = 0; accCycles < 1000; accCycles++)
      begin
         #1;
         if (accDone === 1'b1) break;
         @(posedge ref_clk);
      end
      if (accCycles == 1000)
         chk("accDone", 32'h0, 32'h1);
      else
         chk("accFree", accBusy, 1'b0);
   endtask : acc

   function automatic logic [31:0] mkCfg(logic [11:0] b, logic [11:0] m, logic [1:0] we,
                                         logic dw);
      mhb_win_cfg_t c;
      c = '0;
      c.base = b;
      c.compareMask = m;
      c.waitEnable = we;
      c.dmaWaitEnable = dw;
      c.valid = 1'b1;
      c.widthSelect = 1'b1;
      return c;
   endfunction : mkCfg

   function automatic logic [31:0] mkTim(logic wd, logic to, logic dp);
      mhb_win_tim_t t;
      t = '0;
      t.wrDelay = wd;
      t.timeoutEnable = to;
      t.dmaPolarity = dp;
      t.timeoutClocks = 8'h05;
      return t;
   endfunction : mkTim

   // Expected view of a 16-bit value through an 8-bit device
   function automatic logic [15:0] narrow(logic [15:0] v, logic n);
      return n ? {8'h00, v[7:0]} : v;
   endfunction : narrow

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(80));
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      wreg(8'h4C, 32'hFFFF_FFFF);
      foreach (regTab[k])
      begin
         rreg(regTab[k]);
         chk("resetReg", rd, 32'h0);
      end
      rv = $urandom;
      wreg(8'h08, rv);
      wreg(8'h0C, ~rv);
      rreg(8'h08);
      chk("cfg1", rd, rv);
      rreg(8'h0C);
      chk("tim1", rd, ~rv);
      wreg(8'h08, 32'h0);
      // Window 1 timing left random could invert its select for the rest of the run
      wreg(8'h0C, 32'h0);
      wreg(EN_SET_OFS, 32'h1);
      acc(1'b0, 24'h123456, 16'h0);
      rreg(PEND_OFS);
      chk("umPend", rd, 32'h1);
      chk("irqOn", irqOut, 1'b1);
      wreg(EN_CLR_OFS, 32'h1);
      rreg(EN_SET_OFS);
      chk("enable", rd, 32'h0);
      chk("irqOff", irqOut, 1'b0);
      for (int k = 0; k < 16; k++)
      begin
         base = 12'($urandom);
         mask = 12'($urandom);
         top = k[0] ? (base ^ (12'($urandom) & ~mask)) : 12'($urandom);
         a = {top, 12'($urandom)};
         w = 1'($urandom);
         d = 16'($urandom);
         hit = ((top ^ base) & mask) == 12'h0;
         // Odd k always maps; k[1] picks the shared bus, k[2] the 8-bit device
         wreg(8'h00, mkCfg(base, mask, 2'h0, 1'b0) ^ {4'h0, k[1], 1'b0, k[2], 25'h0});
         wreg(8'h04, $urandom & 32'h81F0_0FFF);
         wreg(PEND_OFS, 32'h3);
         acc(w, a, d);
         chk("select", selSeen, {3'h0, hit});
         chk("latch", latchSeen, hit && k[1]);
         if (hit && !w)
            chk("rdData", accRdData, narrow(a[15:0] ^ 16'h5A3C, k[2]));
         if (hit && w)
            chk("wrData", lastWr, narrow(d, k[2]));
         rreg(PEND_OFS);
         chk("mapPend", rd, {31'h0, !hit});
      end
      wreg(8'h00, mkCfg(12'h800, 12'hFFF, 2'h0, 1'b0));
      for (int wd = 0; wd < 2; wd++)
      begin
         wreg(8'h04, mkTim(wd[0], 1'b0, 1'b0));
         acc(1'b1, 24'h800010, 16'h1234);
         chk("wrLag", 32'((wrT - selT) / 10), 32'(wd * BUS_DIV));
      end
      // Wait held for good: only the timeout can end this access
      holdWait <= 1'b1;
      wreg(8'h04, mkTim(1'b0, 1'b1, 1'b0));
      acc(1'b0, 24'h800020, 16'h0);
      chk("timedOut", accTimedOut, 1'b1);
      chk("toLen", accCycles >= 10, 1'b1);
      rreg(PEND_OFS);
      chk("toPend", rd, 32'h2);
      wreg(8'h04, mkTim(1'b0, 1'b0, 1'b0));
      acc(1'b0, 24'h800030, 16'h0);
      chk("noWait", accTimedOut, 1'b0);
      chk("noWaitData", accRdData, 16'h0030 ^ 16'h5A3C);
      wreg(8'h00, mkCfg(12'h800, 12'hFFF, 2'h1, 1'b0));
      fork
         begin
            repeat (40) @(posedge ref_clk);
            holdWait <= 1'b0;
         end
      join_none
      acc(1'b0, 24'h800040, 16'h0);
      chk("waitLen", accCycles >= 35, 1'b1);
      dmaLow <= 1'b1;
      wreg(8'h00, mkCfg(12'h800, 12'hFFF, 2'h0, 1'b1));
      wreg(8'h04, mkTim(1'b0, 1'b0, 1'b1));
      fork
         begin
            repeat (30) @(posedge ref_clk);
            dmaOn <= 1'b1;
         end
      join_none
      acc(1'b0, 24'h800050, 16'h0);
      chk("dmaLen", accCycles >= 25, 1'b1);
      end_sim();
   end

   initial
   begin
      #200000;
      n_fail++;
      end_sim();
   end
endmodule : master_host_bus_interface_tb
`default_nettype wire
